// ===== hdl/clock_feed_divider.sv
// Purpose: Output divider producing one enable pulse per R clock cycles.
// Assumes: clk_i stands for the selected source clock.
// Notes:   half_i adds an extra divide by two during initial locking.
`timescale 1ns/1ns
module clock_feed_divider
(
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  input  wire logic       run_i,
  input  wire logic [2:0] ratio_i,
  input  wire logic       half_i,
  output logic            tick_o
);

  logic [7:0] count;
  logic [7:0] limit;

  // Factor 1..128 by power of two, doubled when halving is asked
  assign limit = 8'(((9'h001 << ratio_i) << half_i) - 9'h001);

  // Counter restarts whenever the feed is stopped
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !run_i)
    begin
      count  <= 8'h00;
      tick_o <= 1'b0;
    end
    else if (count >= limit)
    begin
      count  <= 8'h00;
      tick_o <= 1'b1;
    end
    else
    begin
      count  <= count + 8'h01;
      tick_o <= 1'b0;
    end
  end

endmodule : clock_feed_divider

// ===== hdl/clock_gen_mode_control.sv
// Purpose: Mode controller of the clock generator with its register file.
// Assumes: Error samples arrive as one-cycle pulses with a signed count.
// Notes:   Oscillator and reference are analog; this steers and reports.
`timescale 1ns/1ns
module clock_gen_mode_control
(
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  input  wire logic        por_i,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [31:0] wb_dat_i,
  input  wire logic [3:0]  wb_sel_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        stop_i,
  input  wire logic        background_debug_i,
  input  wire logic        ext_ref_ok_i,
  input  wire logic        clock_loss_flag_i,
  input  wire logic        ext_ref_edge_i,
  input  wire logic        sample_valid_i,
  input  wire logic [7:0]  count_error_i,
  input  wire logic        osc_static_i,
  output logic      [11:0] loop_filter_value_o,
  output logic      [8:0]  ref_period_o,
  output logic      [2:0]  multiplier_select_o,
  output logic             osc_enable_o,
  output logic             ref_internal_o,
  output logic             generated_clock_out_o
);

  // -----------------------------------------------------------------
  // Helpers
  // -----------------------------------------------------------------
  function automatic logic [7:0] magnitude(input logic [7:0] v);
    magnitude = v[7] ? 8'(-v) : v;
  endfunction : magnitude

  function automatic logic [1:0] mode_code(input clock_gen_pkg::mode_t m);
    case (m)
      clock_gen_pkg::M_INT_UNL, clock_gen_pkg::M_INT_LCK:
        mode_code = clock_gen_pkg::SEL_INT;
      clock_gen_pkg::M_BYPASS:
        mode_code = clock_gen_pkg::SEL_BYP;
      clock_gen_pkg::M_EXT_UNL, clock_gen_pkg::M_EXT_LCK:
        mode_code = clock_gen_pkg::SEL_EXT;
      default:
        mode_code = clock_gen_pkg::SEL_SELF;
    endcase
  endfunction : mode_code

  clock_gen_pkg::state_t st;
  clock_gen_pkg::state_t next_st;

  logic        bus_req;
  logic        wr_upper;
  logic        wr_upper_ok;
  logic        ext_ok;
  logic        halted;
  logic        feed_run;
  logic        tick;
  logic        closed_loop;
  logic        in_lock_win;
  logic        in_unlock_win;
  logic [7:0]  err_delta;
  logic [9:0]  sum4;
  logic [11:0] err_ext;
  logic [11:0] avg_ext;

  // -----------------------------------------------------------------
  // Combinational terms
  // -----------------------------------------------------------------
  // A new request is taken in the cycle before ack rises
  assign bus_req  = wb_cyc_i && wb_stb_i && !st.ack;
  assign wr_upper = bus_req && wb_we_i && wb_sel_i[0] &&
                    wb_adr_i == clock_gen_pkg::FILTER_UPPER_ADR;
  // Writable only when select is self-clocked and no latch pending
  assign wr_upper_ok = wr_upper && st.clock_select == clock_gen_pkg::SEL_SELF
                       && st.latch_busy == 3'h0;
  // Crystal reference is trusted only after its start-up count
  assign ext_ok = ext_ref_ok_i &&
                  (!st.xtal_sel || st.xtal_cnt == clock_gen_pkg::XTAL_CYCLES);
  assign halted = stop_i && !background_debug_i;
  assign closed_loop = st.mode == clock_gen_pkg::M_INT_UNL ||
                       st.mode == clock_gen_pkg::M_INT_LCK ||
                       st.mode == clock_gen_pkg::M_EXT_UNL ||
                       st.mode == clock_gen_pkg::M_EXT_LCK;
  assign in_lock_win   = magnitude(count_error_i) < clock_gen_pkg::LOCK_BOUND;
  assign in_unlock_win = magnitude(count_error_i) <= clock_gen_pkg::UNLOCK_BOUND;
  assign err_delta = magnitude(8'(count_error_i - st.prev_err));
  assign err_ext   = {{4{count_error_i[7]}}, count_error_i};
  assign sum4      = 10'(st.avg_sum + {{2{count_error_i[7]}}, count_error_i});
  assign avg_ext   = {{4{sum4[9]}}, sum4[9:2]};

  // Feed stops in stop and while bypass waits for its reference
  assign feed_run = st.mode != clock_gen_pkg::M_OFF && !halted &&
                    !(st.mode == clock_gen_pkg::M_BYPASS && !ext_ok);

  // -----------------------------------------------------------------
  // Next state
  // -----------------------------------------------------------------
  always_comb
  begin
    next_st = st;
    next_st.ack = bus_req;

    // Register writes
    if (bus_req && wb_we_i && wb_sel_i[0])
    begin
      if (wb_adr_i == clock_gen_pkg::FILTER_UPPER_ADR)
      begin
        if (wr_upper_ok)
        begin
          next_st.pend = {wb_dat_i[3:0], st.lower_hold};
          next_st.latch_busy = clock_gen_pkg::LATCH_CYCLES;
        end
      end
      else if (wb_adr_i == clock_gen_pkg::FILTER_LOWER_ADR)
      begin
        // Outside self-clocked select the write has no effect
        if (st.clock_select == clock_gen_pkg::SEL_SELF)
          next_st.lower_hold = wb_dat_i[7:0];
      end
      else if (wb_adr_i == clock_gen_pkg::TRIM_ADR)
        next_st.trim = wb_dat_i[7:0];
      else if (wb_adr_i == clock_gen_pkg::CONTROL_ADR)
      begin
        next_st.clock_select =
          wb_dat_i[clock_gen_pkg::CTL_SEL_LSB +: 2];
        next_st.multiplier_select =
          wb_dat_i[clock_gen_pkg::CTL_MUL_LSB +: 3];
        next_st.output_divider = wb_dat_i[clock_gen_pkg::CTL_DIV_LSB +: 3];
        next_st.osc_in_stop_enable = wb_dat_i[clock_gen_pkg::CTL_OSC_BIT];
      end
    end
    if (bus_req && wb_we_i && wb_sel_i[1] &&
        wb_adr_i == clock_gen_pkg::CONTROL_ADR)
      next_st.xtal_sel = wb_dat_i[clock_gen_pkg::CTL_XTAL_BIT];

    // Read data, unmapped addresses read zero
    next_st.rdata = 32'h0000_0000;
    if (wb_adr_i == clock_gen_pkg::FILTER_UPPER_ADR)
      next_st.rdata[3:0] = st.filter[11:8];
    else if (wb_adr_i == clock_gen_pkg::FILTER_LOWER_ADR)
      next_st.rdata[7:0] = st.filter[7:0];
    else if (wb_adr_i == clock_gen_pkg::TRIM_ADR)
      next_st.rdata[7:0] = st.trim;
    else if (wb_adr_i == clock_gen_pkg::CONTROL_ADR)
      next_st.rdata[9:0] = {st.xtal_sel, st.osc_in_stop_enable,
                            st.output_divider, st.multiplier_select,
                            st.clock_select};
    else if (wb_adr_i == clock_gen_pkg::STATUS_ADR)
      next_st.rdata[4:0] = {st.xtal_cnt == clock_gen_pkg::XTAL_CYCLES,
                            st.mode == clock_gen_pkg::M_INT_LCK ||
                            st.mode == clock_gen_pkg::M_EXT_LCK,
                            st.stable, st.status};

    // Filter latch sequence completes after a fixed count
    if (st.latch_busy != 3'h0)
    begin
      next_st.latch_busy = st.latch_busy - 3'h1;
      if (st.latch_busy == 3'h1)
        next_st.filter = st.pend;
    end

    // Crystal start-up count of reference edges
    if (st.xtal_sel && ext_ref_edge_i &&
        st.xtal_cnt != clock_gen_pkg::XTAL_CYCLES)
      next_st.xtal_cnt = st.xtal_cnt + 13'h0001;

    // Stability detector on consecutive samples
    if (sample_valid_i && st.mode != clock_gen_pkg::M_OFF)
    begin
      next_st.prev_err = count_error_i;
      next_st.prev_ok = 1'b1;
      next_st.stable = st.prev_ok && !osc_static_i &&
                       err_delta <= clock_gen_pkg::UNLOCK_BOUND;
    end

    // Closed loop: filter tracking and lock detection
    if (closed_loop && sample_valid_i)
    begin
      if (st.mode == clock_gen_pkg::M_INT_UNL ||
          st.mode == clock_gen_pkg::M_EXT_UNL)
      begin
        next_st.filter = st.filter + err_ext;
        next_st.lock_cnt = in_lock_win ? st.lock_cnt + 4'h1 : 4'h0;
        if (in_lock_win && st.lock_cnt == clock_gen_pkg::LOCK_SAMPLES - 4'h1)
        begin
          // Enter locked with a fresh averaging window
          next_st.mode = st.mode == clock_gen_pkg::M_INT_UNL ?
                         clock_gen_pkg::M_INT_LCK :
                         clock_gen_pkg::M_EXT_LCK;
          next_st.ever_locked = 1'b1;
          next_st.half_out = 1'b0;
          next_st.avg_sum = 10'h000;
          next_st.avg_cnt = 2'h0;
          next_st.lock_cnt = 4'h0;
        end
      end
      else if (!in_unlock_win)
      begin
        next_st.mode = st.mode == clock_gen_pkg::M_INT_LCK ?
                       clock_gen_pkg::M_INT_UNL :
                       clock_gen_pkg::M_EXT_UNL;
        next_st.lock_cnt = 4'h0;
      end
      else
      begin
        // Average four errors, then one filter update
        next_st.avg_sum = sum4;
        next_st.avg_cnt = st.avg_cnt + 2'h1;
        if (st.avg_cnt == 2'h3)
        begin
          next_st.filter = st.filter + avg_ext;
          next_st.avg_sum = 10'h000;
        end
      end
    end

    // Mode transitions
    if (halted && !st.osc_in_stop_enable)
    begin
      next_st.mode = clock_gen_pkg::M_OFF;
      next_st.stable = 1'b0;
      next_st.prev_ok = 1'b0;
      next_st.xtal_cnt = 13'h0000;
    end
    else
    begin
      case (st.mode)
        clock_gen_pkg::M_OFF:
        begin
          if (!stop_i || background_debug_i)
          begin
            // Interrupt wake keeps the programmed settings
            if (st.clock_select == clock_gen_pkg::SEL_BYP)
              next_st.mode = clock_gen_pkg::M_BYPASS;
            else
            begin
              next_st.mode = clock_gen_pkg::M_SELF;
              next_st.wake_wait = st.clock_select[0];
            end
          end
        end
        clock_gen_pkg::M_SELF:
        begin
          if (st.clock_select == clock_gen_pkg::SEL_INT &&
              (!st.wake_wait || st.stable))
          begin
            next_st.mode = clock_gen_pkg::M_INT_UNL;
            next_st.wake_wait = 1'b0;
            next_st.lock_cnt = 4'h0;
          end
          else if (st.clock_select == clock_gen_pkg::SEL_EXT && st.stable)
          begin
            // Closed on the internal reference until crystal is ready
            next_st.mode = clock_gen_pkg::M_EXT_UNL;
            next_st.wake_wait = 1'b0;
            next_st.lock_cnt = 4'h0;
            next_st.half_out = !st.ever_locked;
          end
          else if (st.clock_select == clock_gen_pkg::SEL_BYP && ext_ok)
            next_st.mode = clock_gen_pkg::M_BYPASS;
        end
        default:
        begin
          if (st.clock_select == clock_gen_pkg::SEL_SELF ||
              (st.clock_select[1] && !ext_ok && clock_loss_flag_i))
          begin
            // Frequency kept; leaving unlocked drops the extra halving
            next_st.mode = clock_gen_pkg::M_SELF;
            next_st.half_out = 1'b0;
          end
          else if (st.clock_select == clock_gen_pkg::SEL_INT &&
                   mode_code(st.mode) != clock_gen_pkg::SEL_INT)
          begin
            next_st.mode = clock_gen_pkg::M_INT_UNL;
            next_st.lock_cnt = 4'h0;
            next_st.half_out = 1'b0;
          end
        end
      endcase
    end

    // Status crosses two stages before software sees it
    next_st.status_sync = mode_code(st.mode);
    next_st.status = st.status_sync;
  end

  // -----------------------------------------------------------------
  // State register
  // -----------------------------------------------------------------
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      // Defaults applied but the trim survives a non-power-on reset
      st <= '{mode: clock_gen_pkg::M_SELF, filter: clock_gen_pkg::FILTER_RESET,
              multiplier_select: clock_gen_pkg::MUL_RESET,
              output_divider: clock_gen_pkg::DIV_RESET,
              trim: clock_gen_pkg::TRIM_RESET, default: '0};
      if (!por_i)
        st.trim <= st.trim;
    end
    else
      st <= next_st;
  end

  // -----------------------------------------------------------------
  // Output divider and outputs
  // -----------------------------------------------------------------
  clock_feed_divider u_div
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .run_i   (feed_run),
    .ratio_i (st.output_divider),
    .half_i  (st.half_out),
    .tick_o  (tick)
  );

  assign generated_clock_out_o = tick && feed_run;
  assign wb_ack_o            = st.ack;
  assign wb_dat_o            = st.rdata;
  assign loop_filter_value_o = st.filter;
  assign multiplier_select_o = st.multiplier_select;
  // Larger trim shortens the reference period, binary weighted
  assign ref_period_o = clock_gen_pkg::REF_PERIOD_NOM - {1'b0, st.trim};
  assign osc_enable_o = st.mode != clock_gen_pkg::M_BYPASS &&
                        (st.mode != clock_gen_pkg::M_OFF ||
                         st.osc_in_stop_enable);
  assign ref_internal_o = st.mode == clock_gen_pkg::M_INT_UNL ||
                          st.mode == clock_gen_pkg::M_INT_LCK ||
                          (!ext_ok && (st.mode == clock_gen_pkg::M_EXT_UNL ||
                                       st.mode == clock_gen_pkg::M_EXT_LCK));

  // -----------------------------------------------------------------
  // Checks
  // -----------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_latch_loads_filter: assert property (
    wr_upper_ok |-> ##4 st.filter == $past(next_st.pend, 4))
    else $error("filter not loaded when the latch sequence ended");
  a_busy_write_ignored: assert property (
    (wr_upper && st.latch_busy != 3'h0) |=> st.pend == $past(st.pend))
    else $error("upper write during latch changed pending value");
  a_off_on_stop: assert property (
    (halted && !st.osc_in_stop_enable) |=> st.mode == clock_gen_pkg::M_OFF)
    else $error("stop did not reach off state");
  a_feed_gated_stop: assert property (
    halted |-> !generated_clock_out_o &&
               (!st.osc_in_stop_enable || osc_enable_o ||
                st.mode == clock_gen_pkg::M_BYPASS))
    else $error("stop gating or oscillator keep-alive wrong");
  a_bypass_waits_ref: assert property (
    (st.mode == clock_gen_pkg::M_BYPASS && !ext_ok) |->
      !generated_clock_out_o)
    else $error("bypass feed before reference stable");
  a_filter_frozen: assert property (
    (st.clock_select != clock_gen_pkg::SEL_SELF && !closed_loop &&
     st.latch_busy == 3'h0) |=> $stable(st.filter))
    else $error("filter changed outside self-clocked select");
  a_stable_off_clear: assert property (
    st.mode == clock_gen_pkg::M_OFF |-> !st.stable)
    else $error("stable flag set in off state");
  a_status_lag: assert property (
    ##2 st.status == mode_code($past(st.mode, 2)))
    else $error("mode status does not follow mode two cycles later");
  a_ack_single: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("ack held longer than one cycle");

endmodule : clock_gen_mode_control

// ===== inc/clock_gen_pkg.sv
// Purpose: Constants and types shared by the clock generator mode control.
// Assumes: 32-bit classic Wishbone slave, one 100 MHz clock.
// Notes:   All offsets are byte addresses of aligned words.
// What this block does
// - Filter value is read-only unless clock_select is 00.
// - Self-clocked upper filter write loads the whole 12-bit filter value.
// - Upper filter write ignored while a previous latch sequence is running.
// - Filter top four bits in upper 3:0, low eight bits in lower 7:0.
// - Trim is binary weighted; a larger trim gives a shorter reference period.
// - Stop without background debug halts clocks and enters off state.
// - Oscillator-in-stop keeps generators running but gates the clock feed.
// - Interrupt stop exit keeps settings; external loop uses internal ref meanwhile.
// - Interrupt stop exit in external bypass holds feed until reference is stable.
// - Reset stop exit applies defaults, self-clocked nominal, trim kept.
// - With a crystal, 4096 reference cycles are counted before using it.
// - Self-clocked entry: reset, off exit not 10, X1 to 00, lost reference.
// - Self-clocked: loop open, output is oscillator over R, filter writable.
// - Software steers oscillator frequency in self-clocked mode by filter writes.
// - Self-clocked entry keeps frequency; from external loop before first lock after reset output doubles.
// - Off exit with 01 or 11 waits self-clocked until stable, then closes loop.
// - Internal loop entered on 01 write or stable after off exit with 01.
// - Internal unlocked while error outside lock window; output oscillator over R.
// - Locked after error stays inside lock window for the required samples.
// - Locked: filter updated every four samples with their average error.
// - Two-bit mode status, lagging the mode by two cycles through synchronisation.
// - Stable flag: error change within unlock bound, oscillator live; off clears.
// - Output divider field 000..111 gives factor 1..128.
package clock_gen_pkg;

  // ---------------------------------------------------------------
  // Register map
  // ---------------------------------------------------------------
  localparam logic [7:0] FILTER_UPPER_ADR = 8'h00;
  localparam logic [7:0] FILTER_LOWER_ADR = 8'h04;
  localparam logic [7:0] TRIM_ADR         = 8'h08;
  localparam logic [7:0] CONTROL_ADR      = 8'h0c;
  localparam logic [7:0] STATUS_ADR       = 8'h10;

  // Control fields: [1:0] select, [4:2] multiplier, [7:5] divider,
  // [8] oscillator in stop, [9] crystal reference
  localparam int CTL_SEL_LSB  = 0;
  localparam int CTL_MUL_LSB  = 2;
  localparam int CTL_DIV_LSB  = 5;
  localparam int CTL_OSC_BIT  = 8;
  localparam int CTL_XTAL_BIT = 9;

  // ---------------------------------------------------------------
  // Reset values and counts
  // ---------------------------------------------------------------
  localparam logic [11:0] FILTER_RESET = 12'h200; // Nominal self-reset rate
  localparam logic [7:0]  TRIM_RESET   = 8'h80;
  localparam logic [2:0]  MUL_RESET    = 3'h0;
  localparam logic [2:0]  DIV_RESET    = 3'h0;
  localparam logic [2:0]  LATCH_CYCLES = 3'h3;
  localparam logic [3:0]  LOCK_SAMPLES = 4'h4;
  localparam logic [7:0]  LOCK_BOUND   = 8'h04;
  localparam logic [7:0]  UNLOCK_BOUND = 8'h10;
  localparam logic [12:0] XTAL_CYCLES  = 13'h1000;
  localparam logic [8:0]  REF_PERIOD_NOM = 9'h100;

  localparam logic [1:0] SEL_SELF = 2'h0;
  localparam logic [1:0] SEL_INT  = 2'h1;
  localparam logic [1:0] SEL_BYP  = 2'h2;
  localparam logic [1:0] SEL_EXT  = 2'h3;

  // ---------------------------------------------------------------
  // Types
  // ---------------------------------------------------------------
  typedef enum logic [2:0] {
    M_OFF, M_SELF, M_INT_UNL, M_INT_LCK, M_BYPASS, M_EXT_UNL, M_EXT_LCK
  } mode_t;

  typedef struct packed {
    mode_t       mode;
    logic [1:0]  clock_select;
    logic [2:0]  multiplier_select;
    logic [2:0]  output_divider;
    logic        osc_in_stop_enable;
    logic        xtal_sel;
    logic [7:0]  trim;
    logic [7:0]  lower_hold;
    logic [11:0] filter;
    logic [11:0] pend;
    logic [2:0]  latch_busy;
    logic        stable;
    logic        wake_wait;
    logic [7:0]  prev_err;
    logic        prev_ok;
    logic [3:0]  lock_cnt;
    logic [9:0]  avg_sum;
    logic [1:0]  avg_cnt;
    logic        ever_locked;
    logic        half_out;
    logic [12:0] xtal_cnt;
    logic [1:0]  status_sync;
    logic [1:0]  status;
    logic        ack;
    logic [31:0] rdata;
  } state_t;

endpackage : clock_gen_pkg

// ===== test/clock_consumer.sv
// Purpose: Far-side model, a consumer counting generated clock pulses.
// Assumes: Each pulse of feed_i stands for one clock edge delivered.
// Notes:   clear_i zeroes the count so the bench can time a window.
`timescale 1ns/1ns
module clock_consumer
(
  input  wire logic clk_i,
  input  wire logic clear_i,
  input  wire logic feed_i,
  output int        pulses_o
);
  // Unknown feed never counts, so a floating output shows as too few
  always_ff @(posedge clk_i)
  begin
    if (clear_i) pulses_o <= 0;
    else if (feed_i === 1'b1) pulses_o <= pulses_o + 1;
  end
endmodule : clock_consumer

// ===== test/test_clock_gen_mode_control.sv
// Purpose: Self-checking bench of the clock generator mode control.
// Assumes: Classic Wishbone master, one 100 MHz clock.
// Notes:   Loop samples are driven only in the locking scenario.
`timescale 1ns/1ns
module test_clock_gen_mode_control;
  localparam logic [7:0] UA = clock_gen_pkg::FILTER_UPPER_ADR;
  localparam logic [7:0] LA = clock_gen_pkg::FILTER_LOWER_ADR;
  localparam logic [7:0] TA = clock_gen_pkg::TRIM_ADR;
  localparam logic [7:0] CA = clock_gen_pkg::CONTROL_ADR;
  localparam logic [7:0] SA = clock_gen_pkg::STATUS_ADR;
  logic clk_i = 0, rst_i = 1, por_i = 1, cyc = 0, stb = 0, we = 0;
  logic stop = 0, dbg = 0, clr = 0, ack, osc_en, gco;
  logic smp = 0, eok = 0, los = 0, ri;
  logic [2:0] mul;
  logic [7:0] adr = 8'h00, err = 8'h00;
  logic [3:0] sel = 4'h0;
  logic [31:0] dat = 32'h0, q, dout;
  logic [11:0] loop_filter_value, mflt;
  logic [8:0] per;
  logic [7:0] mtrim;
  int seed = 32'h87410036, fails = 0, n_tests = 0, pulses, t, e, acc = 0;
  // ------------------------------------------------------------
  // Design, consumer and clock
  // ------------------------------------------------------------
  clock_gen_mode_control i_clock_gen_mode_control (.clk_i(clk_i),
    .rst_i(rst_i), .por_i(por_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
    .wb_we_i(we), .wb_adr_i(adr), .wb_dat_i(dat), .wb_sel_i(sel),
    .wb_dat_o(dout), .wb_ack_o(ack), .stop_i(stop),
    .background_debug_i(dbg), .ext_ref_ok_i(eok),
    .clock_loss_flag_i(los), .ext_ref_edge_i(1'b0),
    .sample_valid_i(smp), .count_error_i(err), .osc_static_i(1'b0),
    .loop_filter_value_o(loop_filter_value), .ref_period_o(per),
    .multiplier_select_o(mul), .osc_enable_o(osc_en), .ref_internal_o(ri),
    .generated_clock_out_o(gco));
  clock_consumer i_clock_consumer (.clk_i(clk_i), .clear_i(clr),
    .feed_i(gco), .pulses_o(pulses));
  always #5 clk_i = ~clk_i;
  // ------------------------------------------------------------
  // Tasks
  // ------------------------------------------------------------
  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : end_of_test
  task automatic chk(input string nm, input logic [31:0] x,
                     input logic [31:0] g);
    n_tests++;
    if (g !== x)
    begin
      $display("mismatch %s expected %h seen %h", nm, x, g);
      fails++;
    end
  endtask : chk
  // One classic cycle; held until ack is sampled high
  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d);
    int k;
    @(posedge clk_i);
    cyc <= 1; stb <= 1; we <= w; adr <= a; dat <= d; sel <= 4'hf;
    k = 0;
    do begin @(posedge clk_i); k++; end while (ack !== 1'b1 && k < 50);
    q = dout;
    cyc <= 0; stb <= 0; we <= 0;
    if (k >= 50) begin fails++; end_of_test(); end
  endtask : bus
  task automatic rd(input logic [7:0] a, input logic [31:0] x,
                    input logic [31:0] m, input string nm);
    bus(1'b0, a, 32'h0);
    chk(nm, x, q & m);
  endtask : rd
  // Count feed pulses over n cycles
  task automatic count(input int n);
    @(posedge clk_i); clr <= 1;
    @(posedge clk_i); clr <= 0;
    repeat (n) @(posedge clk_i);
    t = pulses;
  endtask : count
  // One comparison sample carrying a signed count error
  task automatic sample(input logic [7:0] v);
    @(posedge clk_i);
    smp <= 1;
    err <= v;
    @(posedge clk_i);
    smp <= 0;
  endtask : sample
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial
  begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    mflt = clock_gen_pkg::FILTER_RESET;
    rd(UA, 32'(mflt[11:8]), 32'hf, "filter upper");
    rd(LA, 32'(mflt[7:0]), 32'hff, "filter lower");
    rd(TA, 32'(clock_gen_pkg::TRIM_RESET), 32'hff, "trim");
    rd(SA, 32'h0, 32'h3, "mode");
    rd(8'h3c, 32'h0, 32'hffffffff, "unmapped");
    mflt = 12'($random(seed)) & 12'h7ff;
    bus(1'b1, LA, 32'(mflt[7:0]));
    bus(1'b1, UA, 32'(mflt[11:8]));
    bus(1'b1, UA, 32'(~mflt[11:8]));
    repeat (4) @(posedge clk_i);
    chk("filter", 32'(mflt), 32'(loop_filter_value));
    rd(UA, 32'(mflt[11:8]), 32'hf, "filter upper");
    rd(LA, 32'(mflt[7:0]), 32'hff, "filter lower");
    repeat (3)
    begin
      mtrim = 8'($random(seed));
      bus(1'b1, TA, 32'(mtrim));
      rd(TA, 32'(mtrim), 32'hff, "trim");
      chk("period", 32'(9'h100 - 9'(mtrim)), 32'(per));
    end
    for (int d = 7; d >= 0; d--)
    begin
      bus(1'b1, CA, 32'(d) << 5);
      repeat (8) @(posedge clk_i);
      count(512);
      e = 512 >> d;
      chk("divided pulses", 32'h1, 32'(t >= e - 1 && t <= e + 1));
    end
    bus(1'b1, CA, 32'h15);
    repeat (6) @(posedge clk_i);
    rd(SA, 32'h1, 32'h3, "mode");
    chk("multiplier", 32'h5, 32'(mul));
    chk("internal ref", 32'h1, 32'(ri));
    bus(1'b1, LA, 32'hff);
    bus(1'b1, UA, 32'hf);
    repeat (4) @(posedge clk_i);
    chk("filter locked out", 32'(mflt), 32'(loop_filter_value));
    // Four small errors lock the loop, four more give one averaged step
    for (int i = 0; i < 8; i++)
    begin
      e = $random(seed) & 3;
      sample(8'(e));
      if (i < 4) mflt = mflt + 12'(e);
      else acc = acc + e;
    end
    mflt = mflt + 12'(acc >> 2);
    rd(SA, 32'hd, 32'h1f, "lock status");
    chk("filter averaged", 32'(mflt), 32'(loop_filter_value));
    bus(1'b1, CA, 32'h0);
    repeat (6) @(posedge clk_i);
    rd(SA, 32'h0, 32'h3, "mode");
    chk("filter kept", 32'(mflt), 32'(loop_filter_value));
    bus(1'b1, CA, 32'h2);
    eok <= 1;
    repeat (6) @(posedge clk_i);
    rd(SA, 32'h2, 32'h3, "mode");
    eok <= 0;
    count(64);
    chk("bypass pulses", 32'h0, 32'(t));
    los <= 1;
    repeat (6) @(posedge clk_i);
    rd(SA, 32'h0, 32'h3, "mode");
    los <= 0;
    bus(1'b1, CA, 32'h0);
    stop <= 1;
    repeat (4) @(posedge clk_i);
    count(64);
    chk("stop pulses", 32'h0, 32'(t));
    chk("stop osc", 32'h0, 32'(osc_en));
    stop <= 0;
    bus(1'b1, CA, 32'h100);
    stop <= 1;
    repeat (4) @(posedge clk_i);
    count(64);
    chk("osc stop pulses", 32'h0, 32'(t));
    chk("osc stop osc", 32'h1, 32'(osc_en));
    dbg <= 1;
    repeat (4) @(posedge clk_i);
    count(64);
    chk("debug pulses", 32'h1, 32'(t >= 63 && t <= 65));
    stop <= 0;
    dbg <= 0;
    repeat (8) @(posedge clk_i);
    rd(CA, 32'h100, 32'h3ff, "control kept");
    rst_i <= 1;
    por_i <= 0;
    repeat (3) @(posedge clk_i);
    rst_i <= 0;
    rd(TA, 32'(mtrim), 32'hff, "trim kept");
    rd(UA, 32'h2, 32'hf, "filter upper");
    rd(CA, 32'h0, 32'h3ff, "control");
    end_of_test();
  end
endmodule : test_clock_gen_mode_control
